// file: gpf_top.sv
`timescale 1ns/1ps
// What this block does
// RQ1: After reset pins 4 to 7 are inputs with no drive.
// RQ2: Irq enable bits 7:4 turn pins 4 to 7 into edge interrupt sources.
// RQ3: One polarity bit per interrupt pin picks its active edge.
// RQ4: A pin used as interrupt source never drives.
// RQ5: Pins 9 to 15 idle after reset; later GPIO or PCI sideband.
// RQ6: PCI mode fixes directions: inputs, outputs 11 and 13, bidir 10. Code drives 11 and 13 only while their pci_oe_i bit is set, as for 10.
// RQ7: Pin 3 is an input after reset.
// RQ8: Pin 0 input by default; may be output or event output.
// RQ9: Pin 8 defaults to serial clock input; may become GPIO 8.
// RQ10: Board strap chooses PCI or host-port plus GPIO 9 to 15.
// RQ11: Interrupt inputs are synchronised; one event per qualifying edge.
module gpf_top (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  input wire logic pci_strap_i,
  input wire logic [15:0] pad_i,
  output logic [15:0] pad_o,
  output logic [15:0] pad_oe_o,
  output logic [6:0] pci_in_o,
  input wire logic [6:0] pci_out_i,
  input wire logic [6:0] pci_oe_i,
  output logic serial2_ext_clock_in_o,
  output logic [3:0] external_irq_event_o
);
  typedef struct packed {
    logic strap_cap;
    logic pci_mode;
    logic [15:0] dir;
    logic [15:0] dout;
    logic [7:0] irq_enable_bits;
    logic [3:0] external_irq_polarity;
    logic [2:0] fsel;
    logic [3:0] stat;
    logic [3:0] mask;
    logic ack;
    logic [31:0] rdata;
    logic general_event_output;
  } gpf_st_t;

  gpf_st_t st_reg;
  gpf_st_t st_next;
  logic [1:0] rsync_reg;
  logic rst_n;
  logic [15:0] pin_sync;
  logic [3:0] evt;
  logic [3:0] irq_sel;
  gpf_pkg::gpf_av_req_t req;
  gpf_pkg::gpf_pad_out_t pad;
  logic wr_hit;
  logic rd_hit;

  // Reset release through two flops; kept out of the state struct since it resets on the raw pin
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rsync_reg <= 2'h0;
    end else begin
      rsync_reg <= {rsync_reg[0], 1'b1};
    end
  end
  assign rst_n = rsync_reg[1];

  assign req.address = avs_address_i;
  assign req.read = avs_read_i;
  assign req.write = avs_write_i;
  assign req.writedata = avs_writedata_i;

  gpf_sync #(
    .W(16)
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .d_i(pad_i),
    .q_o(pin_sync)
  );

  assign irq_sel = st_reg.irq_enable_bits[7:4];

  for (genvar k = 0; k < 4; k++) begin : g_edge
    gpf_edge u_edge (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .lvl_i(pin_sync[4+k]), // [RQ11]
      .pol_i(st_reg.external_irq_polarity[k]),
      .en_i(irq_sel[k]),
      .evt_o(evt[k])
    );
  end

  // Single-cycle answer: wait asserted only in the request's first cycle
  // Writes land only at the edge where waitrequest is seen low
  assign wr_hit = req.write & st_reg.ack;
  assign rd_hit = req.read & ~st_reg.ack;

  always_comb begin
    st_next = st_reg;
    st_next.ack = (req.read | req.write) & ~st_reg.ack;
    // Strap caught once after reset release; board pulldown means non-PCI
    if (!st_reg.strap_cap) begin
      st_next.strap_cap = 1'b1;
      st_next.pci_mode = pci_strap_i; // [RQ10]
    end
    // Hardware set wins over a software clear in the same cycle
    st_next.stat = st_reg.stat;
    if (wr_hit && req.address == gpf_pkg::OFF_STAT) begin
      st_next.stat = st_reg.stat & ~req.writedata[3:0];
    end
    st_next.stat = st_next.stat | evt;
    st_next.general_event_output = |(st_reg.stat & st_reg.mask); // [RQ8]
    if (wr_hit) begin
      case (req.address)
        gpf_pkg::OFF_DIR: st_next.dir = req.writedata[15:0];
        gpf_pkg::OFF_OUT: st_next.dout = req.writedata[15:0];
        gpf_pkg::OFF_IRQEN: st_next.irq_enable_bits = req.writedata[7:0]; // [RQ2]
        gpf_pkg::OFF_POL: st_next.external_irq_polarity = req.writedata[3:0]; // [RQ3]
        gpf_pkg::OFF_FSEL: st_next.fsel = req.writedata[2:0];
        gpf_pkg::OFF_MASK: st_next.mask = req.writedata[3:0];
        default: st_next.dir = st_reg.dir;
      endcase
    end
    if (rd_hit) begin
      case (req.address)
        gpf_pkg::OFF_DIR: st_next.rdata = {16'h0000, st_reg.dir};
        gpf_pkg::OFF_OUT: st_next.rdata = {16'h0000, st_reg.dout};
        gpf_pkg::OFF_IN: st_next.rdata = {16'h0000, pin_sync};
        gpf_pkg::OFF_IRQEN: st_next.rdata = {24'h000000, st_reg.irq_enable_bits};
        gpf_pkg::OFF_POL: st_next.rdata = {28'h0000000, st_reg.external_irq_polarity};
        gpf_pkg::OFF_FSEL: st_next.rdata = {28'h0000000, st_reg.pci_mode, st_reg.fsel};
        gpf_pkg::OFF_STAT: st_next.rdata = {28'h0000000, st_reg.stat};
        gpf_pkg::OFF_MASK: st_next.rdata = {28'h0000000, st_reg.mask};
        default: st_next.rdata = gpf_pkg::BAD_ADDR_DATA;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_reg.strap_cap <= 1'b0;
      st_reg.pci_mode <= 1'b0;
      st_reg.dir <= gpf_pkg::DIR_RST; // [RQ1] [RQ5] [RQ7]
      st_reg.dout <= gpf_pkg::OUT_RST;
      st_reg.irq_enable_bits <= gpf_pkg::IRQEN_RST;
      st_reg.external_irq_polarity <= gpf_pkg::POL_RST;
      st_reg.fsel <= gpf_pkg::FSEL_RST; // [RQ8] [RQ9]
      st_reg.stat <= gpf_pkg::STAT_RST;
      st_reg.mask <= gpf_pkg::MASK_RST;
      st_reg.ack <= 1'b0;
      st_reg.rdata <= 32'h00000000;
      st_reg.general_event_output <= 1'b0;
    end else begin
      st_reg.strap_cap <= st_next.strap_cap;
      st_reg.pci_mode <= st_next.pci_mode;
      st_reg.dir <= st_next.dir;
      st_reg.dout <= st_next.dout;
      st_reg.irq_enable_bits <= st_next.irq_enable_bits;
      st_reg.external_irq_polarity <= st_next.external_irq_polarity;
      st_reg.fsel <= st_next.fsel;
      st_reg.stat <= st_next.stat;
      st_reg.mask <= st_next.mask;
      st_reg.ack <= st_next.ack;
      st_reg.rdata <= st_next.rdata;
      st_reg.general_event_output <= st_next.general_event_output;
    end
  end

  // Pad drive
  always_comb begin
    pad.o = st_reg.dout;
    pad.oe = 16'h0000;
    // Pin 0: input unless output or event output selected
    if (st_reg.fsel[gpf_pkg::FS_GP0_EVT]) begin
      pad.o[0] = st_reg.general_event_output; // [RQ8]
      pad.oe[0] = 1'b1;
    end else if (st_reg.fsel[gpf_pkg::FS_GP0_OUT]) begin
      pad.oe[0] = 1'b1; // [RQ8]
    end
    pad.oe[3:1] = st_reg.dir[3:1]; // [RQ7]
    // Interrupt source pins never drive
    pad.oe[7:4] = st_reg.dir[7:4] & ~irq_sel; // [RQ1] [RQ4]
    pad.oe[8] = st_reg.fsel[gpf_pkg::FS_GP8_IO] & st_reg.dir[8]; // [RQ9]
    if (st_reg.pci_mode) begin
      pad.o[15:9] = pci_out_i;
      pad.oe[15:9] = pci_oe_i & (gpf_pkg::PCI_OUT_PINS | gpf_pkg::PCI_BIDIR_PINS); // [RQ6]
    end else begin
      pad.oe[15:9] = st_reg.dir[15:9]; // [RQ5]
    end
  end

  assign pad_o = pad.o;
  assign pad_oe_o = pad.oe;
  assign pci_in_o = st_reg.pci_mode ? pin_sync[15:9] : 7'h00;
  assign serial2_ext_clock_in_o = st_reg.fsel[gpf_pkg::FS_GP8_IO] ? 1'b0 : pin_sync[8]; // [RQ9]
  assign external_irq_event_o = evt;
  assign irq_o = |(st_reg.stat & st_reg.mask);
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~st_reg.ack;
  assign avs_readdata_o = st_reg.rdata;

  a_irq_pins_quiet: assert property (@(posedge clk_i) disable iff (!rst_n)
    (pad_oe_o[7:4] & irq_sel) == 4'h0) else $error("interrupt pin driven"); // [RQ4]
  a_event_sets_stat: assert property (@(posedge clk_i) disable iff (!rst_n)
    evt[0] |=> st_reg.stat[0]) else $error("event lost"); // [RQ11]
  a_disabled_no_evt: assert property (@(posedge clk_i) disable iff (!rst_n)
    !irq_sel[1] |-> !evt[1]) else $error("event while disabled"); // [RQ2]
  a_rise_detect: assert property (@(posedge clk_i) disable iff (!rst_n)
    irq_sel[0] && !st_reg.external_irq_polarity[0] && $rose(pin_sync[4]) && $stable(irq_sel[0])
    |-> evt[0]) else $error("rising edge missed"); // [RQ3]
  a_pci_in_only: assert property (@(posedge clk_i) disable iff (!rst_n)
    st_reg.pci_mode |-> (pad_oe_o[15:9] & ~(gpf_pkg::PCI_OUT_PINS | gpf_pkg::PCI_BIDIR_PINS)) == 7'h00)
    else $error("PCI input pin driven"); // [RQ6]
  a_gp8_serial: assert property (@(posedge clk_i) disable iff (!rst_n)
    !st_reg.fsel[gpf_pkg::FS_GP8_IO] |-> !pad_oe_o[8]) else $error("pin 8 driven in clock mode"); // [RQ9]
  a_gp0_default: assert property (@(posedge clk_i) disable iff (!rst_n)
    st_reg.fsel[1:0] == 2'h0 |-> !pad_oe_o[0]) else $error("pin 0 driven by default"); // [RQ8]
  a_gp3_follow: assert property (@(posedge clk_i) disable iff (!rst_n)
    pad_oe_o[3] == st_reg.dir[3]) else $error("pin 3 drive mismatch"); // [RQ7]
  a_bus_answer: assert property (@(posedge clk_i) disable iff (!rst_n)
    (avs_read_i && avs_waitrequest_o) |=> (avs_read_i |-> !avs_waitrequest_o))
    else $error("bus answer late"); // single-cycle bus answer
  c_evt_any: cover property (@(posedge clk_i) disable iff (!rst_n) |evt);
  c_irq_out: cover property (@(posedge clk_i) disable iff (!rst_n) irq_o);
  c_pci_mode: cover property (@(posedge clk_i) disable iff (!rst_n) st_reg.pci_mode);
endmodule : gpf_top

// file: gpf_pkg.sv
package gpf_pkg;
  localparam int NPIN = 16;
  // Register offsets (word addresses)
  localparam logic [3:0] OFF_DIR = 4'h0;
  localparam logic [3:0] OFF_OUT = 4'h1;
  localparam logic [3:0] OFF_IN = 4'h2;
  localparam logic [3:0] OFF_IRQEN = 4'h3;
  localparam logic [3:0] OFF_POL = 4'h4;
  localparam logic [3:0] OFF_FSEL = 4'h5;
  localparam logic [3:0] OFF_STAT = 4'h6;
  localparam logic [3:0] OFF_MASK = 4'h7;
  // Field positions in the function select register
  localparam int FS_GP0_OUT = 0;
  localparam int FS_GP0_EVT = 1;
  localparam int FS_GP8_IO = 2;
  // Reset values
  localparam logic [15:0] DIR_RST = 16'h0000;
  localparam logic [15:0] OUT_RST = 16'h0000;
  localparam logic [7:0] IRQEN_RST = 8'h00;
  localparam logic [3:0] POL_RST = 4'h0;
  localparam logic [2:0] FSEL_RST = 3'h0;
  localparam logic [3:0] STAT_RST = 4'h0;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [31:0] BAD_ADDR_DATA = 32'hdeadbeef;
  // PCI pin roles, index is pin-9
  localparam logic [6:0] PCI_OUT_PINS = 7'h14; // pins 11, 13
  localparam logic [6:0] PCI_BIDIR_PINS = 7'h02; // pin 10

  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } gpf_av_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } gpf_av_rsp_t;

  typedef struct packed {
    logic [15:0] o;
    logic [15:0] oe;
  } gpf_pad_out_t;
endpackage : gpf_pkg

// file: gpf_sync.sv
`timescale 1ns/1ps
module gpf_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } gpf_sync_st_t;
  gpf_sync_st_t st_reg;
  gpf_sync_st_t st_next;

  always_comb begin
    st_next.s1 = d_i;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_o = st_reg.s2;
endmodule : gpf_sync

// file: gpf_edge.sv
`timescale 1ns/1ps
module gpf_edge (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic lvl_i,
  input wire logic pol_i,
  input wire logic en_i,
  output logic evt_o
);
  typedef struct packed {
    logic prev;
  } gpf_edge_st_t;
  gpf_edge_st_t st_reg;
  gpf_edge_st_t st_next;
  logic rise;
  logic fall;

  always_comb begin
    st_next.prev = lvl_i;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Edge, not level; one pulse per edge [RQ2] [RQ11]
  assign rise = lvl_i & ~st_reg.prev;
  assign fall = ~lvl_i & st_reg.prev;
  assign evt_o = en_i & (pol_i ? fall : rise); // [RQ3]

  a_edge_one_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    evt_o |=> !evt_o) else $error("edge event longer than one cycle"); // [RQ11]
endmodule : gpf_edge

// file: gpf_board.sv
`timescale 1ns/1ps
module gpf_board (
  input wire logic clk_i,
  input wire logic [15:0] pad_o_i,
  input wire logic [15:0] pad_oe_i,
  input wire logic [15:0] drv_i,
  input wire logic [15:0] drv_en_i,
  input wire logic strap_i,
  input wire logic strap_en_i,
  output logic [15:0] lvl_o,
  output logic strap_o
);
  localparam logic [15:0] PU = 16'h00f0;
  localparam logic [15:0] PD = 16'h0101;
  logic [15:0] last_reg = 16'h0000;
  always_ff @(posedge clk_i) last_reg <= lvl_o;
  // Floating pins without a pull toggle, so a stale value never passes
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (pad_oe_i[i]) lvl_o[i] = pad_o_i[i];
      else if (drv_en_i[i]) lvl_o[i] = drv_i[i];
      else if (PU[i]) lvl_o[i] = 1'b1;
      else if (PD[i]) lvl_o[i] = 1'b0;
      else lvl_o[i] = ~last_reg[i];
    end
  end
  // Pulldown on the strap keeps the non-PCI function
  assign strap_o = strap_en_i ? strap_i : 1'b0;
endmodule : gpf_board

// file: gpf_top_tb.sv
`timescale 1ns/1ps
module gpf_top_tb;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat, seed, q;
  logic wrq, irq, s2clk, strap_w;
  logic strap = 1'b0;
  logic strap_en = 1'b0;
  logic [15:0] pad_o, pad_oe, lvl, dir, out, eoe;
  logic [15:0] drv = 16'h0;
  logic [15:0] drv_en = 16'h0;
  logic [6:0] pci_in;
  logic [6:0] pci_out = 7'h0;
  logic [6:0] pci_oe = 7'h0;
  logic [3:0] evt, pol, st, pv, nv;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int ev_cnt[4];
  int ex[4];
  always #50 clk_i = ~clk_i;
  gpf_top u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_readdata_o(rdat), .avs_waitrequest_o(wrq), .irq_o(irq), .pci_strap_i(strap_w),
    .pad_i(lvl), .pad_o(pad_o), .pad_oe_o(pad_oe), .pci_in_o(pci_in), .pci_out_i(pci_out), .pci_oe_i(pci_oe),
    .serial2_ext_clock_in_o(s2clk), .external_irq_event_o(evt));
  gpf_board u_board (.clk_i(clk_i), .pad_o_i(pad_o), .pad_oe_i(pad_oe), .drv_i(drv), .drv_en_i(drv_en),
    .strap_i(strap), .strap_en_i(strap_en), .lvl_o(lvl), .strap_o(strap_w));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  // Request held until the rising edge that samples waitrequest low; data taken and request released there
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    adr <= a;
    wd <= d;
    rd <= ~w;
    wr <= w;
    @(posedge clk_i);
    while (wrq !== 1'b0) @(posedge clk_i);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rchk
  task automatic rst();
    arst_n_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask : rst
  always @(negedge clk_i) begin
    cyc++;
    for (int k = 0; k < 4; k++) if (evt[k] === 1'b1) ev_cnt[k]++;
    if (cyc > 20000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    seed = 32'h11;
    rst();
    chk(pad_oe, 16'h0);
    rchk(gpf_pkg::OFF_DIR, 32'(gpf_pkg::DIR_RST));
    rchk(gpf_pkg::OFF_IRQEN, 32'(gpf_pkg::IRQEN_RST));
    rchk(gpf_pkg::OFF_FSEL, 32'(gpf_pkg::FSEL_RST));
    rchk(4'h9, gpf_pkg::BAD_ADDR_DATA);
    drv_en <= 16'h0100;
    drv <= 16'h0100;
    repeat (4) @(posedge clk_i);
    chk(s2clk, 1'b1);
    $display("test reset defaults done");
    for (int r = 0; r < 4; r++) begin
      dir = 16'(rnd());
      out = 16'(rnd());
      bus(1'b1, gpf_pkg::OFF_DIR, 32'(dir));
      bus(1'b1, gpf_pkg::OFF_OUT, 32'(out));
      bus(1'b1, gpf_pkg::OFF_FSEL, 32'h4);
      eoe = dir & 16'hfffe;
      pci_oe <= 7'h7f;
      pci_out <= 7'(rnd());
      drv <= 16'(rnd());
      drv_en <= ~eoe;
      repeat (4) @(posedge clk_i);
      chk(pad_oe, eoe);
      chk(pad_o & eoe, out & eoe);
      chk(pci_in, 7'h0);
      chk(s2clk, 1'b0);
      rchk(gpf_pkg::OFF_IN, 32'((out & eoe) | (drv & ~eoe)));
    end
    bus(1'b1, gpf_pkg::OFF_FSEL, 32'h1);
    chk({pad_oe[0], pad_o[0]}, {1'b1, out[0]});
    $display("test gpio directions done");
    bus(1'b1, gpf_pkg::OFF_DIR, 32'h00f0);
    pol = 4'(rnd());
    bus(1'b1, gpf_pkg::OFF_POL, 32'(pol));
    drv_en <= 16'h0070;
    bus(1'b1, gpf_pkg::OFF_MASK, 32'h5);
    bus(1'b1, gpf_pkg::OFF_IRQEN, 32'h70);
    repeat (6) @(posedge clk_i);
    chk(pad_oe[7:4], 4'h8);
    // Dropping the drive on enable can make an edge; start the count from a clean status
    bus(1'b1, gpf_pkg::OFF_STAT, 32'hf);
    ev_cnt = '{default: 0};
    ex = '{default: 0};
    st = 4'h0;
    for (int r = 0; r < 10; r++) begin
      pv = drv[7:4];
      nv = {1'b0, 3'(rnd())};
      drv[7:4] <= nv;
      repeat (6) @(posedge clk_i);
      for (int k = 0; k < 3; k++) if (pol[k] ? (pv[k] & ~nv[k]) : (~pv[k] & nv[k])) begin
        ex[k]++;
        st[k] = 1'b1;
      end
    end
    for (int k = 0; k < 4; k++) chk(ev_cnt[k], ex[k]);
    rchk(gpf_pkg::OFF_STAT, 32'(st));
    chk(irq, |(st & 4'h5));
    bus(1'b1, gpf_pkg::OFF_FSEL, 32'h2);
    chk({pad_oe[0], pad_o[0]}, {1'b1, |(st & 4'h5)});
    bus(1'b1, gpf_pkg::OFF_STAT, 32'(st));
    rchk(gpf_pkg::OFF_STAT, 32'h0);
    chk(irq, 1'b0);
    $display("test external interrupts done");
    strap_en <= 1'b1;
    strap <= 1'b1;
    rst();
    rchk(gpf_pkg::OFF_FSEL, 32'h8);
    bus(1'b1, gpf_pkg::OFF_DIR, 32'hffff);
    pci_out <= 7'(rnd());
    drv <= 16'(rnd());
    drv_en <= ~16'h2cfe;
    repeat (4) @(posedge clk_i);
    chk(pad_oe, 16'h2cfe);
    chk(pad_o[15:9] & 7'h16, pci_out & 7'h16);
    chk(pci_in, (pci_out & 7'h16) | (drv[15:9] & ~7'h16));
    pci_oe <= 7'h0;
    @(posedge clk_i);
    chk(pad_oe[15:9], 7'h0);
    $display("test pci mode done");
    finish_test();
  end
endmodule : gpf_top_tb
